// ---- design/sra_serdes_rx_ctrl.sv ----
// Purpose: mode, comma alignment and self-test control of a serial link endpoint
// Assumes: rx_bit_clk_i ticks once per serial bit; serial inputs are retimed on it
// Notes: control pins are filtered on clk_i, then cross to the bit clock
`timescale 1ns/10ps
`include "sra_params.svh"
module sra_serdes_rx_ctrl (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic rx_bit_clk_i,
  input wire logic rx_clock_rate_select_i,
  input wire logic interface_width_select_i,
  input wire logic comma_align_enable_i,
  input wire logic internal_loopback_enable_i,
  input wire logic pseudo_random_test_enable_i,
  input wire logic device_enable_i,
  input wire logic serial_rx_positive_i,
  input wire logic serial_rx_negative_i,
  input wire logic [9:0] rx_amplitude_mv_i,
  input wire logic [9:0] tx_parallel_word_i,
  output logic [9:0] rx_parallel_word_o,
  output logic rx_parallel_word_oe_o,
  output logic rx_byte_clock_a_o,
  output logic rx_byte_clock_b_o,
  output logic rx_byte_clock_oe_o,
  output logic serial_tx_positive_o,
  output logic serial_tx_negative_o,
  output logic serial_tx_oe_o,
  output logic comma_detect_o,
  output logic signal_present_flag_o,
  output logic ten_bit_parallel_mode_o,
  output logic input_pull_enable_o
);

  // ---------------- control pins on clk_i ----------------
  logic [`SRA_CTRL_BITS-1:0] pin_bus;
  logic [`SRA_CTRL_BITS-1:0] ctrl_sys;

  assign pin_bus = {device_enable_i, comma_align_enable_i, rx_clock_rate_select_i,
                    interface_width_select_i, internal_loopback_enable_i,
                    pseudo_random_test_enable_i};

  sra_pin_sync #(
    .W(`SRA_CTRL_BITS),
    .RST_VAL(`SRA_CTRL_PULL_DEFAULT)
  ) u_pin_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pin_i(pin_bus),
    .level_o(ctrl_sys)
  );

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ten_bit_parallel_mode_o <= 1'b1;
      input_pull_enable_o <= 1'b1;
    end else begin
      ten_bit_parallel_mode_o <= ~ctrl_sys[`SRA_CTRL_WIDTH];
      input_pull_enable_o <= ctrl_sys[`SRA_CTRL_ENABLE];
    end
  end

  // ---------------- reset and control into the bit clock ----------------
  logic lk_rst_meta_ff;
  logic lk_rst_n_ff;
  logic [`SRA_CTRL_BITS-1:0] lk_ctrl_meta_ff;
  logic [`SRA_CTRL_BITS-1:0] lk_ctrl_ff;

  always_ff @(posedge rx_bit_clk_i) begin
    lk_rst_meta_ff <= reset_n_i;
    lk_rst_n_ff <= lk_rst_meta_ff;
  end

  always_ff @(posedge rx_bit_clk_i) begin
    if (!lk_rst_n_ff) begin
      lk_ctrl_meta_ff <= `SRA_CTRL_PULL_DEFAULT;
      lk_ctrl_ff <= `SRA_CTRL_PULL_DEFAULT;
    end else begin
      lk_ctrl_meta_ff <= ctrl_sys;
      lk_ctrl_ff <= lk_ctrl_meta_ff;
    end
  end

  logic lk_enable;
  logic lk_align;
  logic lk_loop;
  logic lk_prbs;
  sra_pkg::sra_clk_mode_t clk_mode;

  assign lk_enable = lk_ctrl_ff[`SRA_CTRL_ENABLE];
  assign lk_align = lk_ctrl_ff[`SRA_CTRL_ALIGN];
  assign lk_loop = lk_ctrl_ff[`SRA_CTRL_LOOP];
  assign lk_prbs = lk_ctrl_ff[`SRA_CTRL_PRBS];

  always_comb begin
    if (lk_ctrl_ff[`SRA_CTRL_WIDTH]) begin
      clk_mode = sra_pkg::CLK_DDR;
    end else if (lk_ctrl_ff[`SRA_CTRL_RATE]) begin
      clk_mode = sra_pkg::CLK_FULL;
    end else begin
      clk_mode = sra_pkg::CLK_HALF;
    end
  end

  // ---------------- transmit serialiser and pattern generator ----------------
  logic [3:0] tx_rem_ff;
  logic [9:0] tx_sh_ff;
  logic [9:0] tx_cur;
  logic [6:0] gen_ff;
  logic gen_bit;
  logic tx_bit_ff;

  assign gen_bit = gen_ff[6] ^ gen_ff[5];

  always_comb begin
    tx_cur = tx_sh_ff;
    if (clk_mode == sra_pkg::CLK_DDR) begin
      if (tx_rem_ff == `SRA_REM_LAST || tx_rem_ff == `SRA_REM_HALF) begin
        tx_cur = {5'h00, tx_parallel_word_i[4:0]};
      end
    end else if (tx_rem_ff == `SRA_REM_LAST) begin
      tx_cur = tx_parallel_word_i;
    end
  end

  always_ff @(posedge rx_bit_clk_i) begin
    if (!lk_rst_n_ff) begin
      tx_rem_ff <= `SRA_REM_LAST;
    end else if (tx_rem_ff == 4'h0) begin
      tx_rem_ff <= `SRA_REM_LAST;
    end else begin
      tx_rem_ff <= tx_rem_ff - 4'h1;
    end
  end

  always_ff @(posedge rx_bit_clk_i) begin
    if (!lk_rst_n_ff) begin
      tx_sh_ff <= 10'h000;
    end else begin
      tx_sh_ff <= {1'b0, tx_cur[9:1]};
    end
  end

  always_ff @(posedge rx_bit_clk_i) begin
    if (!lk_rst_n_ff || !lk_prbs) begin
      gen_ff <= `SRA_PRBS_SEED;
    end else begin
      gen_ff <= {gen_ff[5:0], gen_bit};
    end
  end

  always_ff @(posedge rx_bit_clk_i) begin
    if (!lk_rst_n_ff) begin
      tx_bit_ff <= 1'b0;
    end else begin
      tx_bit_ff <= lk_prbs ? gen_bit : tx_cur[0];
    end
  end

  always_ff @(posedge rx_bit_clk_i) begin
    if (!lk_rst_n_ff) begin
      serial_tx_positive_o <= 1'b0;
      serial_tx_negative_o <= 1'b1;
      serial_tx_oe_o <= 1'b0;
    end else begin
      serial_tx_positive_o <= lk_prbs ? gen_bit : tx_cur[0];
      serial_tx_negative_o <= ~(lk_prbs ? gen_bit : tx_cur[0]);
      serial_tx_oe_o <= lk_enable & ~lk_loop;
    end
  end

  // ---------------- receive bit source ----------------
  logic rx_bit;

  // the loopback path bypasses the serial inputs entirely
  assign rx_bit = lk_loop ? tx_bit_ff : (serial_rx_positive_i & ~serial_rx_negative_i);

  // ---------------- comma search and word framing ----------------
  logic [6:0] comma_sh_ff;
  logic [6:0] nxt_comma_sh;
  logic [9:0] word_sh_ff;
  logic [9:0] nxt_word_sh;
  logic [3:0] word_rem_ff;
  logic comma_hit;
  logic realign;

  assign nxt_comma_sh = {comma_sh_ff[5:0], rx_bit};
  assign nxt_word_sh = {word_sh_ff[8:0], rx_bit};
  assign comma_hit = (nxt_comma_sh == `SRA_COMMA_PATTERN);
  // a comma already on the boundary needs no realignment
  assign realign = lk_align && comma_hit && (word_rem_ff != 4'h3);

  always_ff @(posedge rx_bit_clk_i) begin
    if (!lk_rst_n_ff) begin
      comma_sh_ff <= 7'h00;
      word_sh_ff <= 10'h000;
    end else begin
      comma_sh_ff <= nxt_comma_sh;
      word_sh_ff <= nxt_word_sh;
    end
  end

  always_ff @(posedge rx_bit_clk_i) begin
    if (!lk_rst_n_ff) begin
      word_rem_ff <= `SRA_REM_LAST;
    end else if (realign) begin
      word_rem_ff <= `SRA_REM_AFTER_COMMA;
    end else if (word_rem_ff == 4'h0) begin
      word_rem_ff <= `SRA_REM_LAST;
    end else begin
      word_rem_ff <= word_rem_ff - 4'h1;
    end
  end

  // first received bit goes to bit 0 of the word
  function automatic logic [9:0] sra_bit_reverse(input logic [9:0] w);
    logic [9:0] r;
    r = 10'h000;
    for (int i = 0; i < `SRA_WORD_BITS; i++) begin
      r[i] = w[`SRA_WORD_BITS-1-i];
    end
    return r;
  endfunction

  logic [9:0] cap_word_ff;

  always_ff @(posedge rx_bit_clk_i) begin
    if (!lk_rst_n_ff) begin
      cap_word_ff <= 10'h000;
    end else if (word_rem_ff == 4'h0) begin
      cap_word_ff <= sra_bit_reverse(nxt_word_sh);
    end
  end

  // ---------------- byte clock generation ----------------
  logic [3:0] clk_rem_ff;
  logic half_phase_ff;
  logic rise_next;

  // the clock counter freezes until it meets the word counter, so a realign
  // only ever lengthens the current clock level
  always_ff @(posedge rx_bit_clk_i) begin
    if (!lk_rst_n_ff) begin
      clk_rem_ff <= `SRA_REM_LAST;
    end else if (clk_rem_ff != word_rem_ff) begin
      clk_rem_ff <= clk_rem_ff;
    end else if (clk_rem_ff == 4'h0) begin
      clk_rem_ff <= `SRA_REM_LAST;
    end else begin
      clk_rem_ff <= clk_rem_ff - 4'h1;
    end
  end

  assign rise_next = (clk_rem_ff == word_rem_ff) && (clk_rem_ff == 4'h5);

  always_ff @(posedge rx_bit_clk_i) begin
    if (!lk_rst_n_ff) begin
      half_phase_ff <= 1'b0;
    end else if (rise_next) begin
      half_phase_ff <= ~half_phase_ff;
    end
  end

  logic full_level;

  // high over the last five bits of a word, low over the first five
  assign full_level = (clk_rem_ff <= `SRA_REM_HALF);

  always_ff @(posedge rx_bit_clk_i) begin
    if (!lk_rst_n_ff) begin
      rx_byte_clock_a_o <= 1'b0;
      rx_byte_clock_b_o <= 1'b0;
    end else begin
      case (clk_mode)
        sra_pkg::CLK_HALF: begin
          rx_byte_clock_a_o <= half_phase_ff;
          rx_byte_clock_b_o <= ~half_phase_ff;
        end
        sra_pkg::CLK_FULL: begin
          rx_byte_clock_a_o <= full_level;
          rx_byte_clock_b_o <= 1'b0;
        end
        sra_pkg::CLK_DDR: begin
          rx_byte_clock_a_o <= full_level;
          rx_byte_clock_b_o <= 1'b0;
        end
        default: begin
          rx_byte_clock_a_o <= 1'b0;
          rx_byte_clock_b_o <= 1'b0;
        end
      endcase
    end
  end

  // ---------------- receive word output ----------------
  always_ff @(posedge rx_bit_clk_i) begin
    if (!lk_rst_n_ff) begin
      rx_parallel_word_o <= 10'h000;
    end else if (clk_mode == sra_pkg::CLK_DDR) begin
      // first half before the rising edge, second half before the falling edge
      if (clk_rem_ff == `SRA_REM_LAST) begin
        rx_parallel_word_o <= {5'h00, cap_word_ff[4:0]};
      end else if (clk_rem_ff == `SRA_REM_HALF) begin
        rx_parallel_word_o <= {5'h00, cap_word_ff[9:5]};
      end
    end else if (clk_rem_ff == `SRA_REM_LAST) begin
      rx_parallel_word_o <= cap_word_ff;
    end
  end

  always_ff @(posedge rx_bit_clk_i) begin
    if (!lk_rst_n_ff) begin
      rx_parallel_word_oe_o <= 1'b0;
      rx_byte_clock_oe_o <= 1'b0;
    end else begin
      rx_parallel_word_oe_o <= lk_enable;
      rx_byte_clock_oe_o <= lk_enable;
    end
  end

  // ---------------- pattern checker ----------------
  logic [6:0] chk_ff;
  logic [3:0] good_cnt_ff;
  logic chk_expect;
  logic nxt_pass;

  assign chk_expect = chk_ff[6] ^ chk_ff[5];

  always_ff @(posedge rx_bit_clk_i) begin
    if (!lk_rst_n_ff) begin
      chk_ff <= 7'h00;
    end else begin
      chk_ff <= {chk_ff[5:0], rx_bit};
    end
  end

  // a run of clean bits first fills the checker, so it locks on its own
  always_ff @(posedge rx_bit_clk_i) begin
    if (!lk_rst_n_ff || !lk_prbs) begin
      good_cnt_ff <= 4'h0;
    end else if (rx_bit != chk_expect) begin
      good_cnt_ff <= 4'h0;
    end else if (good_cnt_ff != `SRA_PRBS_LOCK_BITS) begin
      good_cnt_ff <= good_cnt_ff + 4'h1;
    end
  end

  assign nxt_pass = (rx_bit == chk_expect) && (good_cnt_ff == `SRA_PRBS_LOCK_BITS);

  always_ff @(posedge rx_bit_clk_i) begin
    if (!lk_rst_n_ff) begin
      comma_detect_o <= 1'b0;
    end else if (lk_prbs) begin
      comma_detect_o <= nxt_pass;
    end else begin
      comma_detect_o <= lk_align & comma_hit;
    end
  end

  // ---------------- signal present ----------------
  always_ff @(posedge rx_bit_clk_i) begin
    if (!lk_rst_n_ff) begin
      signal_present_flag_o <= 1'b0;
    end else if (rx_amplitude_mv_i > `SRA_SIG_HIGH_MV) begin
      signal_present_flag_o <= 1'b1;
    end else if (rx_amplitude_mv_i < `SRA_SIG_LOW_MV) begin
      signal_present_flag_o <= 1'b0;
    end
  end

endmodule // sra_serdes_rx_ctrl

// ---- design/sra_params.svh ----
// Purpose: shared constants of the receive align and test control block
// Assumes: included by every design file that needs a count or a default
// Notes: one bit time of the link clock is one serial bit
`ifndef SRA_PARAMS_SVH
`define SRA_PARAMS_SVH

// serial bits in one parallel word, and the first down-count value of a word
`define SRA_WORD_BITS 10
`define SRA_REM_LAST 4'h9
// down-count value at which the second half of a word begins
`define SRA_REM_HALF 4'h4
// comma bits in arrival order, first bit received leftmost
`define SRA_COMMA_PATTERN 7'h1F
// down-count loaded on a comma so that the word closes three bits later
`define SRA_REM_AFTER_COMMA 4'h2
// amplitude thresholds of the signal-present flag, in mV
`define SRA_SIG_HIGH_MV 10'h096
`define SRA_SIG_LOW_MV 10'h032
// clean bits the checker needs before it reports a pass
`define SRA_PRBS_LOCK_BITS 4'hF
`define SRA_PRBS_SEED 7'h7F
// pin defaults through internal pulls: {enable, align, rate, width, loop, prbs}
`define SRA_CTRL_PULL_DEFAULT 6'h30
`define SRA_CTRL_ENABLE 5
`define SRA_CTRL_ALIGN 4
`define SRA_CTRL_RATE 3
`define SRA_CTRL_WIDTH 2
`define SRA_CTRL_LOOP 1
`define SRA_CTRL_PRBS 0
`define SRA_CTRL_BITS 6

`endif

// ---- design/sra_pkg.sv ----
// Purpose: types of the receive align and test control block
// Assumes: nothing
// Notes: constants live in sra_params.svh
package sra_pkg;

  typedef enum logic [1:0] {
    CLK_HALF,
    CLK_FULL,
    CLK_DDR
  } sra_clk_mode_t;

endpackage

// ---- design/sra_pin_sync.sv ----
// Purpose: three-flop pin synchroniser with agreement filter
// Assumes: pins are asynchronous to clk_i
// Notes: the output changes only once stages two and three agree
`timescale 1ns/10ps
module sra_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      level_o <= RST_VAL;
    end else begin
      level_o <= (s2_ff & ~(s2_ff ^ s3_ff)) | (level_o & (s2_ff ^ s3_ff));
    end
  end

endmodule // sra_pin_sync

// ---- bench/sra_rx_ctrl_monitor.sv ----
// Purpose: port checker of the receive align and test control block
// Assumes: pins hold at least twelve control clocks between changes
// Notes: pin relations wait out the pin filter and the crossing
`timescale 1ns/10ps
module sra_rx_ctrl_monitor (
  input wire logic reset_n_i,
  input wire logic rx_bit_clk_i,
  input wire logic rx_clock_rate_select_i,
  input wire logic interface_width_select_i,
  input wire logic comma_align_enable_i,
  input wire logic internal_loopback_enable_i,
  input wire logic pseudo_random_test_enable_i,
  input wire logic device_enable_i,
  input wire logic [9:0] rx_amplitude_mv_i,
  input wire logic [9:0] rx_parallel_word_o,
  input wire logic rx_parallel_word_oe_o,
  input wire logic rx_byte_clock_a_o,
  input wire logic rx_byte_clock_b_o,
  input wire logic rx_byte_clock_oe_o,
  input wire logic serial_tx_oe_o,
  input wire logic comma_detect_o,
  input wire logic signal_present_flag_o
);
  logic [5:0] run_ff;
  logic ok;
  always_ff @(posedge rx_bit_clk_i) begin
    if (!reset_n_i)
      run_ff <= 6'h00;
    else if (run_ff != 6'h3F)
      run_ff <= run_ff + 6'h01;
  end
  assign ok = (run_ff == 6'h3F);
  default clocking cb @(posedge rx_bit_clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_half;
    ok && !rx_clock_rate_select_i && !$past(rx_clock_rate_select_i, 48) &&
      !interface_width_select_i && !$past(interface_width_select_i, 48)
      |-> rx_byte_clock_a_o != rx_byte_clock_b_o;
  endproperty
  a_half: assert property (p_half) else $error("clocks not opposed");
  property p_b_low;
    ok && (interface_width_select_i && $past(interface_width_select_i, 48) ||
      rx_clock_rate_select_i && $past(rx_clock_rate_select_i, 48)) |-> !rx_byte_clock_b_o;
  endproperty
  a_b_low: assert property (p_b_low) else $error("clock b runs");
  property p_upper;
    ok && interface_width_select_i && $past(interface_width_select_i, 48)
      |-> rx_parallel_word_o[9:5] == 5'h00;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  // a mode switch may cut a phase; only realignment must never shorten one
  property p_hi5;
    ok && rx_clock_rate_select_i == $past(rx_clock_rate_select_i, 48) &&
      interface_width_select_i == $past(interface_width_select_i, 48) &&
      $rose(rx_byte_clock_a_o) |-> rx_byte_clock_a_o [*5];
  endproperty
  a_hi5: assert property (p_hi5) else $error("clock a high short");
  property p_lo5;
    ok && rx_clock_rate_select_i == $past(rx_clock_rate_select_i, 48) &&
      interface_width_select_i == $past(interface_width_select_i, 48) &&
      $fell(rx_byte_clock_a_o) |-> !rx_byte_clock_a_o [*5];
  endproperty
  a_lo5: assert property (p_lo5) else $error("clock a low short");
  property p_no_det;
    ok && !comma_align_enable_i && !$past(comma_align_enable_i, 48) &&
      !pseudo_random_test_enable_i && !$past(pseudo_random_test_enable_i, 48)
      |-> !comma_detect_o;
  endproperty
  a_no_det: assert property (p_no_det) else $error("detect while off");
  property p_pulse;
    ok && !pseudo_random_test_enable_i && !$past(pseudo_random_test_enable_i, 48) &&
      comma_detect_o |=> !comma_detect_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("detect too long");
  property p_loop;
    ok && internal_loopback_enable_i && $past(internal_loopback_enable_i, 48)
      |-> !serial_tx_oe_o;
  endproperty
  a_loop: assert property (p_loop) else $error("tx driven in loop");
  property p_off;
    ok && !device_enable_i && !$past(device_enable_i, 48)
      |-> !(rx_parallel_word_oe_o | rx_byte_clock_oe_o | serial_tx_oe_o);
  endproperty
  a_off: assert property (p_off) else $error("driven while off");
  property p_sig_hi;
    ok && rx_amplitude_mv_i > 10'h096 |=> signal_present_flag_o;
  endproperty
  a_sig_hi: assert property (p_sig_hi) else $error("flag low");
  property p_sig_lo;
    ok && rx_amplitude_mv_i < 10'h032 |=> !signal_present_flag_o;
  endproperty
  a_sig_lo: assert property (p_sig_lo) else $error("flag high");
  c_det: cover property (comma_detect_o && !pseudo_random_test_enable_i);
  c_pass: cover property (comma_detect_o && pseudo_random_test_enable_i);
  c_loop: cover property (internal_loopback_enable_i && !serial_tx_oe_o);
endmodule // sra_rx_ctrl_monitor

// ---- bench/sra_link_partner.sv ----
// Purpose: far-end serial source repeating one ten-bit word
// Assumes: word_i changes away from the rising bit clock edge
// Notes: bit 0 leaves first; lines change just after the rising edge
`timescale 1ns/10ps
module sra_link_partner (
  input wire logic rx_bit_clk_i,
  input wire logic [9:0] word_i,
  output logic serial_p_o = 1'b0,
  output logic serial_n_o = 1'b1
);
  logic [3:0] idx_ff = 4'h0;
  always_ff @(posedge rx_bit_clk_i) begin
    serial_p_o <= word_i[idx_ff];
    serial_n_o <= ~word_i[idx_ff];
    idx_ff <= (idx_ff == 4'h9) ? 4'h0 : idx_ff + 4'h1;
  end
endmodule // sra_link_partner

// ---- bench/sra_serdes_rx_ctrl_bench.sv ----
// Purpose: self-checking bench of the receive align and test control block
// Assumes: pins change one at a time with long holds, except loopback one control clock after rate select
// Notes: word checks use the value standing just before a clock a edge
`timescale 1ns/10ps
module sra_serdes_rx_ctrl_bench;
  logic clk_i = 1'b0;
  logic rx_bit_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic rx_clock_rate_select_i = 1'b0;
  logic interface_width_select_i = 1'b0;
  logic comma_align_enable_i = 1'b1;
  logic internal_loopback_enable_i = 1'b0;
  logic pseudo_random_test_enable_i = 1'b0;
  logic device_enable_i = 1'b1;
  logic serial_rx_positive_i, serial_rx_negative_i;
  logic [9:0] rx_amplitude_mv_i = 10'h0C8;
  logic [9:0] tx_parallel_word_i = 10'h17C;
  logic [9:0] far_word = 10'h17C;
  logic [9:0] rx_parallel_word_o;
  logic rx_parallel_word_oe_o, rx_byte_clock_a_o, rx_byte_clock_b_o, rx_byte_clock_oe_o;
  logic serial_tx_positive_o, serial_tx_negative_o, serial_tx_oe_o, comma_detect_o;
  logic signal_present_flag_o, ten_bit_parallel_mode_o, input_pull_enable_o;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  localparam logic [9:0] AMPS [4] = '{10'h0C8, 10'h064, 10'h014, 10'h064};
  always #25 clk_i = ~clk_i;
  always #6 rx_bit_clk_i = ~rx_bit_clk_i;
  sra_serdes_rx_ctrl sra_serdes_rx_ctrl_i (.clk_i, .reset_n_i, .rx_bit_clk_i,
    .rx_clock_rate_select_i, .interface_width_select_i, .comma_align_enable_i,
    .internal_loopback_enable_i, .pseudo_random_test_enable_i, .device_enable_i,
    .serial_rx_positive_i, .serial_rx_negative_i, .rx_amplitude_mv_i, .tx_parallel_word_i,
    .rx_parallel_word_o, .rx_parallel_word_oe_o, .rx_byte_clock_a_o, .rx_byte_clock_b_o,
    .rx_byte_clock_oe_o, .serial_tx_positive_o, .serial_tx_negative_o, .serial_tx_oe_o,
    .comma_detect_o, .signal_present_flag_o, .ten_bit_parallel_mode_o, .input_pull_enable_o);
  sra_link_partner sra_link_partner_i (.rx_bit_clk_i, .word_i(far_word),
    .serial_p_o(serial_rx_positive_i), .serial_n_o(serial_rx_negative_i));
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic hold;
    repeat (20) @(negedge clk_i);
  endtask
  // word standing just before clock a reaches lvl
  task automatic word_at(input logic lvl, output logic [9:0] w);
    logic pa;
    int i;
    i = 0;
    pa = lvl;
    while (i < 40 && !(pa === ~lvl && rx_byte_clock_a_o === lvl)) begin
      @(posedge rx_bit_clk_i);
      pa = rx_byte_clock_a_o;
      w = rx_parallel_word_o;
      #1;
      i++;
    end
  endtask
  task automatic det_seen(output logic got);
    got = 1'b0;
    repeat (40) begin
      @(posedge rx_bit_clk_i);
      #1;
      if (comma_detect_o === 1'b1)
        got = 1'b1;
    end
  endtask
  // transmitted word framed on its comma; both lines must stay complementary
  task automatic tx_seen(output logic [9:0] w);
    logic [9:0] sh;
    logic bad;
    sh = 10'h000;
    bad = 1'b0;
    w = 10'h3FF;
    for (int i = 0; i < 30; i++) begin
      @(posedge rx_bit_clk_i);
      #1;
      sh = {serial_tx_positive_o, sh[9:1]};
      if (serial_tx_negative_o !== ~serial_tx_positive_o)
        bad = 1'b1;
      if (i >= 9 && sh[6:0] == 7'h7C)
        w = sh;
    end
    if (bad)
      w = 10'h3FF;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    logic [9:0] w;
    logic got;
    repeat (8) @(negedge clk_i);
    check(ten_bit_parallel_mode_o, 1'b1);
    check(input_pull_enable_o, 1'b1);
    reset_n_i = 1'b1;
    hold();
    rx_clock_rate_select_i = 1'b1;
    hold();
    word_at(1'b1, w);
    check(w, 10'h17C);
    det_seen(got);
    check(got, 1'b1);
    tx_seen(w);
    check(w, 10'h17C);
    interface_width_select_i = 1'b1;
    hold();
    check(ten_bit_parallel_mode_o, 1'b0);
    word_at(1'b1, w);
    check(w, 10'h01C);
    word_at(1'b0, w);
    check(w, 10'h00B);
    rx_clock_rate_select_i = 1'b0;
    hold();
    word_at(1'b1, w);
    check(w, 10'h01C);
    check(rx_byte_clock_b_o, 1'b0);
    interface_width_select_i = 1'b0;
    hold();
    check(ten_bit_parallel_mode_o, 1'b1);
    comma_align_enable_i = 1'b0;
    hold();
    det_seen(got);
    check(got, 1'b0);
    comma_align_enable_i = 1'b1;
    hold();
    rx_clock_rate_select_i = 1'b1;
    @(negedge rx_bit_clk_i);
    far_word = 10'h155;
    @(negedge clk_i);
    internal_loopback_enable_i = 1'b1;
    hold();
    check(serial_tx_oe_o, 1'b0);
    word_at(1'b1, w);
    check(w, 10'h17C);
    pseudo_random_test_enable_i = 1'b1;
    hold();
    check(comma_detect_o, 1'b1);
    internal_loopback_enable_i = 1'b0;
    hold();
    check(serial_tx_oe_o, 1'b1);
    check(comma_detect_o, 1'b0);
    pseudo_random_test_enable_i = 1'b0;
    hold();
    device_enable_i = 1'b0;
    hold();
    check({rx_parallel_word_oe_o, rx_byte_clock_oe_o, serial_tx_oe_o}, 3'h0);
    check(input_pull_enable_o, 1'b0);
    device_enable_i = 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(negedge rx_bit_clk_i);
      rx_amplitude_mv_i = AMPS[k];
      repeat (3) @(negedge rx_bit_clk_i);
      check(signal_present_flag_o, k < 2);
    end
    tally_and_finish();
  end
endmodule // sra_serdes_rx_ctrl_bench
bind sra_serdes_rx_ctrl sra_rx_ctrl_monitor sra_rx_ctrl_monitor_i (.reset_n_i, .rx_bit_clk_i,
  .rx_clock_rate_select_i, .interface_width_select_i, .comma_align_enable_i,
  .internal_loopback_enable_i, .pseudo_random_test_enable_i, .device_enable_i,
  .rx_amplitude_mv_i, .rx_parallel_word_o, .rx_parallel_word_oe_o, .rx_byte_clock_a_o,
  .rx_byte_clock_b_o, .rx_byte_clock_oe_o, .serial_tx_oe_o, .comma_detect_o,
  .signal_present_flag_o);
